// ==== core/pse_defines.svh ====
// Constants for the PSE serial control port: addresses, timing, defaults.
// Assumes a 200 MHz system clock and a two-wire bus sampled from pins.
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH
`define PSE_CLK_MHZ 200
`define PSE_SHED_NS 6500
`define PSE_SHED_CYC ((`PSE_SHED_NS * `PSE_CLK_MHZ) / 1000)
`define PSE_BCAST_ADDR 7'h30
`define PSE_ARA_ADDR 7'h0c
`define PSE_ADDR_FIX_MASK 7'h30
`define PSE_ADDR_FIX_VAL 7'h20
`define PSE_REG_CHIP_RESET 8'h1a
`define PSE_REG_MSD_INV 8'h27
`define PSE_REG_GPIO 8'h41
`define PSE_MSD_INV_RST 1'b0
`endif

// ==== core/pse_pkg.sv ====
// Types for the PSE serial control port.
// Assumes pse_defines.svh for all numbers except the one-hot state codes.
package pse_pkg;
  typedef enum logic [6:0] {
    PSE_IDLE = 7'h01,
    PSE_ADDR = 7'h02,
    PSE_AACK = 7'h04,
    PSE_WRX = 7'h08,
    PSE_WACK = 7'h10,
    PSE_RTX = 7'h20,
    PSE_RACK = 7'h40
  } pse_st_t;
endpackage

// ==== core/pse_shed.sv ====
// Masked-shutdown port shedding for eight ports.
// Assumes masked input is already synchronised to CLK_SYS.
`timescale 1ns/1ps
`include "pse_defines.svh"
module pse_shed (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msd_sync,
  input wire logic msd_inv,
  input wire logic [7:0] prio_high,
  input wire logic [7:0] det_en_set,
  output logic [7:0] det_en,
  output logic [7:0] shed_pulse
);
  import pse_pkg::*;
  logic act;
  logic act_d_r;
  // ==========================================
  // Polarity and edge
  assign act = msd_inv ? msd_sync : ~msd_sync;
  always_ff @(posedge clk) begin
    if (!rst_n) act_d_r <= 1'b0;
    else act_d_r <= act;
  end
  // ==========================================
  // Enables; single-cycle shed is well inside the allowed time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      det_en <= 8'h00;
      shed_pulse <= 8'h00;
    end else if (act) begin
      det_en <= det_en & prio_high;
      shed_pulse <= det_en & ~prio_high;
    end else begin
      det_en <= det_en | det_en_set;
      shed_pulse <= 8'h00;
    end
  end
  property p_shed_fast;
    @(posedge clk) disable iff (!rst_n)
      act |=> ((det_en & ~prio_high) == 8'h00);
  endproperty
  a_shed_fast: assert property (p_shed_fast)
    else $error("low priority port still enabled");
  // Delayed activity marks a shed already under way
  property p_keep_high;
    @(posedge clk) disable iff (!rst_n)
      act && act_d_r |-> ((det_en & prio_high) == ($past(det_en) & prio_high));
  endproperty
  a_keep_high: assert property (p_keep_high)
    else $error("high priority port disturbed");
endmodule

// ==== core/pse_i2c_port.sv ====
// Two-wire target port of an eight-port PSE controller, two quads.
// Assumes bus pins and shutdown pin are asynchronous to CLK_SYS.
`timescale 1ns/1ps
`include "pse_defines.svh"
module pse_i2c_port (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SCL_IN,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  output logic INT_OE,
  input wire logic ADDRESS_SELECT_HIGH,
  input wire logic [3:0] ADDRESS_SELECT_LOW,
  input wire logic MASKED_SHUTDOWN_IN,
  input wire logic [7:0] PRIO_HIGH,
  input wire logic [7:0] EVENT_IN,
  input wire logic [7:0] EVENT_MASK,
  input wire logic [7:0] RD_DATA_Q0,
  input wire logic [7:0] RD_DATA_Q1,
  input wire logic [7:0] DET_EN_SET,
  output logic [7:0] DET_EN,
  output logic [7:0] SHED_PULSE,
  output logic [7:0] WR_DATA,
  output logic [7:0] WR_REG,
  output logic [1:0] WR_QUAD,
  output logic WR_STB,
  output logic MSD_INV,
  output logic BUSY
);
  import pse_pkg::*;
  // ==========================================
  // Synchronisers
  logic [2:0] scl_s_r, sda_s_r;
  logic [1:0] msd_s_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      msd_s_r <= 2'h3;
    end else begin
      scl_s_r <= {scl_s_r[1:0], SCL_IN};
      sda_s_r <= {sda_s_r[1:0], SERIAL_DATA_IN};
      msd_s_r <= {msd_s_r[0], MASKED_SHUTDOWN_IN};
    end
  end
  logic scl, sda, scl_p, sda_p;
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  assign scl_p = scl_s_r[2];
  assign sda_p = sda_s_r[2];
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl & ~scl_p;
  assign scl_fall = ~scl & scl_p;
  assign start_c = scl & scl_p & sda_p & ~sda;
  assign stop_c = scl & scl_p & ~sda_p & sda;
  // ==========================================
  // Addresses
  logic [6:0] base_addr;
  logic int_act;
  assign base_addr = {ADDRESS_SELECT_HIGH, 2'b10, ADDRESS_SELECT_LOW};
  function automatic logic legal(input logic [6:0] a);
    legal = (a & `PSE_ADDR_FIX_MASK) == `PSE_ADDR_FIX_VAL;
  endfunction
  // ==========================================
  // Interrupt: wired-OR, pull low while any enabled event is pending
  logic [7:0] ev_pend_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) INT_OE <= 1'b0;
    else INT_OE <= |(EVENT_IN & EVENT_MASK);
  end
  assign ev_pend_r = EVENT_IN & EVENT_MASK;
  assign int_act = INT_OE;
  // ==========================================
  // Bus engine
  pse_st_t st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic rw_r, ara_r, bc_r, quad_r, have_reg_r;
  logic [7:0] reg_r;
  logic [7:0] rd_sh_r;
  logic [6:0] own_q_addr;
  assign own_q_addr = quad_r ? (base_addr + 7'h01) : base_addr;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_r <= PSE_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      rw_r <= 1'b0;
      ara_r <= 1'b0;
      bc_r <= 1'b0;
      quad_r <= 1'b0;
      have_reg_r <= 1'b0;
      reg_r <= 8'h00;
      rd_sh_r <= 8'h00;
      SERIAL_DATA_OE <= 1'b0;
      WR_STB <= 1'b0;
      WR_DATA <= 8'h00;
      WR_REG <= 8'h00;
      WR_QUAD <= 2'b00;
    end else begin
      WR_STB <= 1'b0;
      if (start_c) begin
        st_r <= PSE_ADDR;
        bit_r <= 4'h0;
        have_reg_r <= 1'b0;
        SERIAL_DATA_OE <= 1'b0;
      end else if (stop_c) begin
        st_r <= PSE_IDLE;
        SERIAL_DATA_OE <= 1'b0;
      end else begin
        case (st_r)
          PSE_IDLE: SERIAL_DATA_OE <= 1'b0;
          PSE_ADDR: if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            rw_r <= sh_r[0];
            bc_r <= sh_r[7:1] == `PSE_BCAST_ADDR;
            ara_r <= int_act && sh_r[7:1] == `PSE_ARA_ADDR && sh_r[0];
            quad_r <= sh_r[7:1] == (base_addr + 7'h01);
            if ((legal(sh_r[7:1]) && (sh_r[7:1] == base_addr ||
                sh_r[7:1] == base_addr + 7'h01)) ||
                (sh_r[7:1] == `PSE_BCAST_ADDR && !sh_r[0]) ||
                (int_act && sh_r[7:1] == `PSE_ARA_ADDR && sh_r[0])) begin
              SERIAL_DATA_OE <= 1'b1;
              st_r <= PSE_AACK;
            end else st_r <= PSE_IDLE;
          end
          PSE_AACK: if (scl_fall) begin
            bit_r <= 4'h0;
            if (rw_r) begin
              rd_sh_r <= ara_r ? {own_q_addr, 1'b0} :
                (quad_r ? RD_DATA_Q1 : RD_DATA_Q0);
              SERIAL_DATA_OE <= ara_r ? ~own_q_addr[6] :
                ~(quad_r ? RD_DATA_Q1[7] : RD_DATA_Q0[7]);
              st_r <= PSE_RTX;
            end else begin
              SERIAL_DATA_OE <= 1'b0;
              st_r <= PSE_WRX;
            end
          end
          PSE_WRX: if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            SERIAL_DATA_OE <= 1'b1;
            if (!have_reg_r) begin
              reg_r <= sh_r;
              have_reg_r <= 1'b1;
            end else begin
              WR_STB <= 1'b1;
              WR_DATA <= sh_r;
              WR_REG <= reg_r;
              reg_r <= reg_r + 8'h01;
              // Broadcast writes and global registers hit both quads; others only the addressed one
              if (bc_r || reg_r == `PSE_REG_CHIP_RESET || reg_r == `PSE_REG_MSD_INV ||
                  reg_r == `PSE_REG_GPIO) WR_QUAD <= 2'b11;
              else WR_QUAD <= quad_r ? 2'b10 : 2'b01;
            end
            st_r <= PSE_WACK;
          end
          PSE_WACK: if (scl_fall) begin
            SERIAL_DATA_OE <= 1'b0;
            bit_r <= 4'h0;
            st_r <= PSE_WRX;
          end
          PSE_RTX: if (scl_fall) begin
            if (bit_r == 4'hf) begin
              // Byte after a host ack: bit 7 goes out first, shifting starts next fall
              SERIAL_DATA_OE <= ~rd_sh_r[7];
              bit_r <= 4'h0;
            end else if (bit_r == 4'h7) begin
              SERIAL_DATA_OE <= 1'b0;
              st_r <= PSE_RACK;
            end else begin
              SERIAL_DATA_OE <= ~rd_sh_r[6];
              rd_sh_r <= {rd_sh_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
            end
          end
          PSE_RACK: if (scl_rise) begin
            if (sda) st_r <= PSE_IDLE;
            else begin
              rd_sh_r <= quad_r ? RD_DATA_Q1 : RD_DATA_Q0;
              bit_r <= 4'hf;
              st_r <= PSE_RTX;
            end
          end
          default: st_r <= PSE_IDLE;
        endcase
      end
    end
  end
  // Data out is held low; open drain uses the enable only
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) SERIAL_DATA_OUT <= 1'b0;
    else SERIAL_DATA_OUT <= 1'b0;
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) BUSY <= 1'b0;
    else BUSY <= st_r != PSE_IDLE;
  end
  // ==========================================
  // Polarity register, shared by both quads
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) MSD_INV <= `PSE_MSD_INV_RST;
    else if (WR_STB && WR_REG == `PSE_REG_MSD_INV) MSD_INV <= WR_DATA[0];
  end
  pse_shed u_shed (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .msd_sync(msd_s_r[1]),
    .msd_inv(MSD_INV),
    .prio_high(PRIO_HIGH),
    .det_en_set(DET_EN_SET),
    .det_en(DET_EN),
    .shed_pulse(SHED_PULSE)
  );
  // ==========================================
  // Checks
  sequence s_addr_done;
    st_r == PSE_ADDR && scl_fall && bit_r == 4'h8;
  endsequence
  property p_no_illegal;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_addr_done ##0 (!legal(sh_r[7:1]) && sh_r[7:1] != `PSE_ARA_ADDR &&
      sh_r[7:1] != `PSE_BCAST_ADDR) |=> !SERIAL_DATA_OE;
  endproperty
  a_no_illegal: assert property (p_no_illegal) else $error("illegal address acked");
  property p_ack_base;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_addr_done ##0 (sh_r[7:1] == base_addr) |=> SERIAL_DATA_OE && st_r == PSE_AACK;
  endproperty
  a_ack_base: assert property (p_ack_base) else $error("own address not acked");
  property p_ara_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_addr_done ##0 (sh_r[7:1] == `PSE_ARA_ADDR && !int_act) |=> st_r == PSE_IDLE;
  endproperty
  a_ara_gate: assert property (p_ara_gate) else $error("alert answered idle");
  property p_int;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (|ev_pend_r) |=> INT_OE;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not raised");
  property p_int_clear;
    @(posedge CLK_SYS) disable iff (!RST_N)
      !(|ev_pend_r) |=> !INT_OE;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("stray interrupt");
  property p_ara_ack;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_addr_done ##0 (sh_r == {`PSE_ARA_ADDR, 1'b1} && int_act) |=> SERIAL_DATA_OE;
  endproperty
  a_ara_ack: assert property (p_ara_ack) else $error("alert not answered");
  property p_bcast_ack;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_addr_done ##0 (sh_r == {`PSE_BCAST_ADDR, 1'b0}) |=> SERIAL_DATA_OE;
  endproperty
  a_bcast_ack: assert property (p_bcast_ack) else $error("broadcast not acked");
endmodule

// ==== tb/pse_host_model.sv ====
// Host bus master model for the two-wire target port.
// Assumes a pull-up on the shared data line; SCL rests high outside frames.
`timescale 1ns/1ps
module pse_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ==========================
  // Bus timing, 64 ns bit period
  localparam int Q = 16;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start_c();
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  // Data moves mid-low so it never changes while SCL is high
  task automatic bit_x(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // A released bit (1) lets the target drive; ack_drv 1 releases the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ack_drv, output logic [7:0] q,
      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_drv, ack);
  endtask
  task automatic stop_c();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask
endmodule

// ==== tb/pse_i2c_port_tb_top.sv ====
// Self-checking bench for the two-wire target port with its host model.
// Assumes straps 1/0101 give base address 7'h65 and quad 1 at 7'h66.
`timescale 1ns/1ps
module pse_i2c_port_tb_top;
  typedef struct packed {logic [6:0] a; logic [7:0] r; logic [7:0] d; logic ack;
    logic [1:0] q;} pse_row_t;
  logic clk_sys, rst_n, masked_shutdown_in, scl, sda_low, sd_out, sd_oe, int_oe, wr_stb, busy;
  logic msd_inv, ak, shed_clr;
  logic [7:0] ev, evm, dset, det_en, shed, wr_d, wr_r, q, shed_seen, l_d, l_r;
  logic [1:0] wr_q, l_q;
  int err_count, checked, stb_n, n0, k;
  pse_row_t rows [10];
  wire sda = !(sda_low || (sd_oe && !sd_out)); // Joined data pins, pulled up
  pse_host_model h (.scl(scl), .sda_low(sda_low), .sda(sda));
  pse_i2c_port i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SCL_IN(scl),
    .SERIAL_DATA_IN(sda), .SERIAL_DATA_OUT(sd_out), .SERIAL_DATA_OE(sd_oe),
    .INT_OE(int_oe), .ADDRESS_SELECT_HIGH(1'b1), .ADDRESS_SELECT_LOW(4'h5),
    .MASKED_SHUTDOWN_IN(masked_shutdown_in), .PRIO_HIGH(8'h0f), .EVENT_IN(ev), .EVENT_MASK(evm),
    .RD_DATA_Q0(8'h3c), .RD_DATA_Q1(8'hc3), .DET_EN_SET(dset), .DET_EN(det_en),
    .SHED_PULSE(shed), .WR_DATA(wr_d), .WR_REG(wr_r), .WR_QUAD(wr_q), .WR_STB(wr_stb),
    .MSD_INV(msd_inv), .BUSY(busy));
  // ==========================
  // Clock and monitors
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    shed_seen <= shed_clr ? 8'h00 : shed_seen | shed;
    if (wr_stb === 1'b1) begin
      stb_n <= stb_n + 1;
      {l_q, l_r, l_d} <= {wr_q, wr_r, wr_d};
    end
  end
  // ==========================
  // Checks and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ==========================
  // Main sequence
  initial begin
    {rst_n, masked_shutdown_in, ev, evm, dset, shed_clr, stb_n, err_count, checked} = '0;
    masked_shutdown_in = 1'b1;
    rows = '{'{7'h65, 8'h10, 8'ha5, 1'b1, 2'b01}, '{7'h66, 8'h11, 8'h5a, 1'b1, 2'b10},
      '{7'h30, 8'h12, 8'h3c, 1'b1, 2'b11}, '{7'h65, 8'h41, 8'h81, 1'b1, 2'b11},
      '{7'h66, 8'h1a, 8'h00, 1'b1, 2'b11}, '{7'h66, 8'h27, 8'h01, 1'b1, 2'b11},
      '{7'h45, 8'h00, 8'h00, 1'b0, 2'b00}, '{7'h75, 8'h00, 8'h00, 1'b0, 2'b00},
      '{7'h67, 8'h00, 8'h00, 1'b0, 2'b00}, '{7'h0c, 8'h00, 8'h00, 1'b0, 2'b00}};
    wait_clk(2);
    rst_n = 1'b1;
    wait_clk(3);
    chk({det_en, shed, msd_inv, busy, int_oe, sd_oe, wr_stb}, 0);
    $display("test reset done");
    foreach (rows[i]) begin
      n0 = stb_n;
      h.start_c();
      h.xfer({rows[i].a, 1'b0}, 1'b1, q, ak);
      chk(ak, !rows[i].ack);
      if (rows[i].ack) begin
        h.xfer(rows[i].r, 1'b1, q, ak);
        h.xfer(rows[i].d, 1'b1, q, ak);
      end
      h.stop_c();
      wait_clk(4);
      chk(stb_n - n0, rows[i].ack);
      if (rows[i].ack) chk({l_q, l_r, l_d}, {rows[i].q, rows[i].r, rows[i].d});
      chk({busy, sd_oe, sd_out}, 0);
    end
    $display("test addressing done");
    chk(msd_inv, 1);
    // Polarity is now active high, so a low input keeps every port up
    masked_shutdown_in = 1'b0;
    dset = 8'hff;
    wait_clk(8);
    dset = 8'h00;
    shed_clr = 1'b1;
    wait_clk(2);
    shed_clr = 1'b0;
    chk(det_en, 8'hff);
    masked_shutdown_in = 1'b1;
    for (k = 0; k < 1300 && det_en !== 8'h0f; k++) wait_clk(1);
    chk(det_en, 8'h0f);
    wait_clk(4);
    chk(shed_seen, 8'hf0);
    masked_shutdown_in = 1'b0;
    wait_clk(20);
    chk(det_en, 8'h0f);
    dset = 8'hff;
    wait_clk(4);
    chk(det_en, 8'hff);
    $display("test shed done");
    ev = 8'h04;
    evm = 8'h0c;
    wait_clk(6);
    chk({int_oe, ev[2] && evm[2]}, 2'b11);
    h.start_c(); // Shared line: host asks who alerted
    h.xfer({7'h0c, 1'b1}, 1'b1, q, ak);
    chk(ak, 0);
    h.xfer(8'hff, 1'b1, q, ak);
    chk(q, 8'hca);
    h.stop_c();
    evm = 8'h00;
    wait_clk(6);
    chk(int_oe, 0);
    h.start_c();
    h.xfer({7'h66, 1'b1}, 1'b1, q, ak);
    h.xfer(8'hff, 1'b1, q, ak);
    h.stop_c();
    chk(q, 8'hc3);
    h.start_c();
    h.xfer({7'h65, 1'b1}, 1'b1, q, ak);
    h.xfer(8'hff, 1'b0, q, ak);
    chk(q, 8'h3c);
    h.xfer(8'hff, 1'b1, q, ak);
    h.stop_c();
    chk(q, 8'h3c);
    $display("test alert and read done");
    results();
  end
  initial begin
    #400us;
    err_count++;
    results();
  end
endmodule
